// ### core/tcs_pkg.sv
// Package: constants shared by the turn counter and fuse status core
package tcs_pkg;
	// Serial command codes
	localparam int         CMD_W        = 5;
	localparam logic [4:0] CMD_RD_ANGLE = 5'h00;
	localparam logic [4:0] CMD_RD_MULTI = 5'h01;
	localparam logic [4:0] CMD_RD_ANA   = 5'h09;
	localparam logic [4:0] CMD_RD_FUSE  = 5'h0f;
	localparam logic [4:0] CMD_HYSTERESIS_RESET_CMD = 5'h13;
	localparam logic [4:0] CMD_FUSE_VOLTAGE_PIN     = 5'h19;
	localparam logic [4:0] CMD_WR_FUSE  = 5'h1f;
	// Frame lengths and counter positions
	localparam int         FUSE_W       = 46;
	localparam int         CUST_W       = 16;
	localparam int         REP_W        = 12;
	localparam logic [5:0] CMD_LAST     = 6'h04;
	localparam logic [5:0] FUSE_LAST    = 6'h2d;
	localparam logic [5:0] RST_POS      = 6'h02;
	localparam logic [5:0] CNT_MAX      = 6'h3f;
	// Fuse word fields
	localparam int         RED_LO       = 12;
	localparam int         RED_HI       = 15;
	localparam int         SENS_LO      = 9;
	localparam int         SENS_HI      = 11;
	localparam int         ZERO_HI      = 7;
	localparam logic [3:0] RED_FIRST    = 4'h1;
	localparam logic [3:0] RED_LAST     = 4'hc;
	// Gain value at its upper limit
	localparam logic [5:0] GAIN_MAX     = 6'h3f;
	// APB register map
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_FUSE_LO  = 8'h08;
	localparam logic [7:0] OFS_FUSE_HI  = 8'h0c;
	// Serial frame phases
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_CMD  = 2'b01,
		PH_DATA = 2'b10
	} tcs_phase_t;
endpackage : tcs_pkg

// ### core/tcs_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module tcs_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	// Both stages in one state word
	typedef struct packed {
		logic [WIDTH-1:0] meta;   // First stage, read only by second
		logic [WIDTH-1:0] stable; // Second stage, safe to use
	} tcs_sync_t;

	tcs_sync_t q;      // Current state
	tcs_sync_t next_q; // Next state

	// Shift the pin through both stages
	always_comb begin
		next_q.meta   = async_in;
		next_q.stable = q.meta;
	end

	// Register the stages
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign sync_out = q.stable;
endmodule : tcs_sync

// ### core/tcs_repair.sv
// Redundancy repair of the customer fuse bits
`timescale 1ns/10ps
module tcs_repair
	import tcs_pkg::*;
(
	input  wire logic [CUST_W-1:0] raw_bits,
	output logic      [REP_W-1:0]  fixed_bits
);
	logic [3:0] sel; // Repair selector field

	assign sel = raw_bits[RED_HI:RED_LO];

	// Each customer bit is forced high only when its code is selected; one driver per bit
	for (genvar i = 0; i < REP_W; i++) begin : g_bit
		logic hit; // This bit is the one picked for repair
		assign hit = (sel >= RED_FIRST) && (sel <= RED_LAST) && (sel == 4'(i + 1));
		assign fixed_bits[i] = raw_bits[i] | hit; // OR can only set, never clear
	end
endmodule : tcs_repair

// ### core/tcs_core.sv
// Turn counter, fuse word decode and serial command core
`timescale 1ns/10ps
module tcs_core
	import tcs_pkg::*;
#(
	parameter logic [FUSE_W-CUST_W-1:0] FACTORY_TRIM = 30'h0 // Arbitrary neutral trim value
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Serial command pins
	input  wire logic        serial_clock_pin,
	input  wire logic        serial_select_n,
	input  wire logic        serial_data_in,
	output logic             serial_data_out,
	// Fuse voltage pin, two-way
	input  wire logic        fuse_voltage_in,
	output logic             fuse_voltage_out,
	output logic             fuse_voltage_oe,
	// Sensor front end, same clock
	input  wire logic [7:0]  angle_in,
	input  wire logic [5:0]  agc_in,
	input  wire logic        adc_lock,
	input  wire logic        cross_cw,
	input  wire logic        cross_ccw,
	// Status and configuration
	output logic             field_strength_pin,
	output logic [2:0]       gain_setting,
	output logic             low_power
);
	// Whole module state
	typedef struct packed {
		tcs_phase_t        phase;     // Serial frame phase
		logic [5:0]        bit_cnt;   // Bits seen in current phase
		logic [4:0]        cmd;       // Latched command code
		logic [FUSE_W-1:0] shift_in;  // Incoming write data
		logic [FUSE_W-1:0] shift_out; // Outgoing read data
		logic              sdo;       // Serial data out
		logic              ana_drive; // Fuse pin driven by analog readout
		logic [5:0]        ana_idx;   // Fuse bit on the pin
		logic [FUSE_W-1:0] shadow;    // Fuse word as stored
		logic [7:0]        turns;     // Signed revolution count
		logic              sclk_q;    // Previous serial clock sample
		logic              sleep;     // Low power request
		logic [2:0]        gain;      // Customer gain setting
		logic              gain_sel;  // Use customer gain over fuse
		logic              field_ok;  // Field strength indication
		logic [2:0]        gain_out;  // Selected gain
		logic [31:0]       rdata;     // APB read data
	} tcs_state_t;

	tcs_state_t        q;          // Current state
	tcs_state_t        next_q;     // Next state
	logic [3:0]        pins;       // Synchronised pins
	logic              sclk_s;     // Synced serial clock
	logic              sel_n_s;    // Synced select
	logic              sdi_s;      // Synced data in
	logic              vprog_s;    // Synced programming voltage
	logic [REP_W-1:0]  fixed;      // Repaired customer bits
	logic [FUSE_W-1:0] fuse_eff;   // Fuse word after repair
	logic              lock_rep;   // Reported lock
	logic [7:0]        angle_rep;  // Reported angle
	logic              apb_hit;    // Address is mapped

	// Bring pins into the clock domain
	tcs_sync #(
		.WIDTH(4)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_in({serial_clock_pin, serial_select_n, serial_data_in, fuse_voltage_in}),
		.sync_out(pins)
	);

	assign {sclk_s, sel_n_s, sdi_s, vprog_s} = pins;

	// Repair customer bits from stored fuse word
	tcs_repair u_repair (
		.raw_bits  (q.shadow[CUST_W-1:0]),
		.fixed_bits(fixed)
	);

	// Decoded word seen by readback and config
	assign fuse_eff = {q.shadow[FUSE_W-1:REP_W], fixed};

	// Lock masked in low power mode
	assign lock_rep = adc_lock & ~q.sleep;

	// Angle relative to fused zero, direction kept
	assign angle_rep = angle_in - fuse_eff[ZERO_HI:0];

	// Decode of mapped APB offsets
	assign apb_hit = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) ||
		(paddr == OFS_FUSE_LO) || (paddr == OFS_FUSE_HI);

	// Read frame for a command, MSB first
	function automatic logic [FUSE_W-1:0] frame_for(input logic [4:0] c);
		logic [7:0] val;
		logic [16:0] fr;
		val = (c == CMD_RD_MULTI) ? q.turns : angle_rep;
		fr = {lock_rep, agc_in, 1'b0, val, 1'b0}; // Lock, gain, spare zero, value and parity slot of frame
		fr[0] = ^fr[16:1]; // Even parity over frame
		frame_for = {fr, 29'h0};
		if (c == CMD_RD_FUSE) begin
			frame_for = fuse_eff; // Same layout as program word
		end
	endfunction : frame_for

	// Next-state logic
	always_comb begin
		logic [FUSE_W-1:0] sh;
		logic [4:0]        cmd_n;
		logic              clr;
		sh = {q.shift_in[FUSE_W-2:0], sdi_s};
		cmd_n = {q.cmd[3:0], sdi_s};
		clr = 1'b0;
		next_q = q;
		next_q.sclk_q = sclk_s;
		// Serial framing
		if (sel_n_s) begin
			next_q.phase     = PH_IDLE;
			next_q.bit_cnt   = '0;
			next_q.ana_drive = 1'b0;
		end else if (sclk_s && !q.sclk_q) begin
			// Rising serial clock: sample data in
			unique case (q.phase)
				PH_IDLE, PH_CMD: begin
					next_q.cmd     = cmd_n;
					next_q.bit_cnt = q.bit_cnt + 6'h01;
					next_q.phase   = PH_CMD;
					if (q.bit_cnt == CMD_LAST) begin
						next_q.phase     = PH_DATA;
						next_q.bit_cnt   = '0;
						next_q.shift_out = frame_for(cmd_n);
						next_q.ana_drive = (cmd_n == CMD_RD_ANA);
						next_q.ana_idx   = '0;
					end
				end
				PH_DATA: begin
					next_q.shift_in = sh;
					if (q.bit_cnt != CNT_MAX) begin
						next_q.bit_cnt = q.bit_cnt + 6'h01;
					end
					// Step through fuse word one bit per clock
					if (q.ana_drive && (q.ana_idx != FUSE_LAST)) begin
						next_q.ana_idx = q.ana_idx + 6'h01;
					end
					// Counter reset bit clears at this edge
					if ((q.cmd == CMD_HYSTERESIS_RESET_CMD) && (q.bit_cnt == RST_POS) && sdi_s) begin
						clr = 1'b1;
					end
					// Burn from command 25, customer bits only
					if ((q.cmd == CMD_FUSE_VOLTAGE_PIN) && (q.bit_cnt == FUSE_LAST) && vprog_s) begin
						next_q.shadow[CUST_W-1:0] = q.shadow[CUST_W-1:0] | sh[CUST_W-1:0];
					end
					// Volatile write of the whole word
					if ((q.cmd == CMD_WR_FUSE) && (q.bit_cnt == FUSE_LAST)) begin
						next_q.shadow = sh;
					end
				end
				default: begin
					next_q.phase = PH_IDLE;
				end
			endcase
		end else if (!sclk_s && q.sclk_q && (q.phase == PH_DATA)) begin
			// Falling serial clock: present next read bit
			next_q.sdo       = q.shift_out[FUSE_W-1];
			next_q.shift_out = {q.shift_out[FUSE_W-2:0], 1'b0};
		end
		// Revolution count, clear first so later crossings count
		next_q.turns = clr ? 8'h00 : q.turns;
		if (cross_cw && !cross_ccw) begin
			next_q.turns = next_q.turns + 8'h01;
		end else if (cross_ccw && !cross_cw) begin
			next_q.turns = next_q.turns - 8'h01;
		end
		// Field strength flag
		next_q.field_ok = (agc_in != GAIN_MAX);
		// Gain from fuse or customer register
		next_q.gain_out = q.gain_sel ? q.gain : fuse_eff[SENS_HI:SENS_LO];
		// APB write to control
		if (psel && penable && pwrite && (paddr == OFS_CTRL)) begin
			next_q.sleep    = pwdata[0];
			next_q.gain     = pwdata[3:1];
			next_q.gain_sel = pwdata[4];
		end
		// APB read data captured in setup phase
		if (psel && !penable) begin
			unique case (paddr)
				OFS_CTRL:    next_q.rdata = {27'h0, q.gain_sel, q.gain, q.sleep};
				OFS_STATUS:  next_q.rdata = {16'h0, agc_in, q.field_ok, lock_rep, q.turns};
				OFS_FUSE_LO: next_q.rdata = fuse_eff[31:0];
				OFS_FUSE_HI: next_q.rdata = {18'h0, fuse_eff[FUSE_W-1:32]};
				default:     next_q.rdata = 32'h0;
			endcase
		end
	end

	// State register, counter starts at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q        <= '0;
			q.phase  <= PH_IDLE;
			q.shadow <= {FACTORY_TRIM, 16'h0};
		end else begin
			q <= next_q;
		end
	end

	// APB answers with no wait state
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~apb_hit;
	assign prdata  = q.rdata;

	// Pin and configuration outputs
	assign serial_data_out    = q.sdo;
	assign fuse_voltage_oe    = q.ana_drive;
	assign fuse_voltage_out   = q.ana_drive & fuse_eff[q.ana_idx];
	assign field_strength_pin = q.field_ok;
	assign gain_setting       = q.gain_out;
	assign low_power          = q.sleep;
endmodule : tcs_core

// ### bench/tcs_core_assertions.sv
// Port-level checker for the turn counter core
`timescale 1ns/10ps
module tcs_core_assertions
	import tcs_pkg::*;
#(
	parameter logic [FUSE_W-CUST_W-1:0] FACTORY_TRIM = 30'h0
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        serial_select_n,
	input wire logic        fuse_voltage_oe,
	input wire logic [5:0]  agc_in,
	input wire logic        adc_lock,
	input wire logic        field_strength_pin,
	input wire logic [2:0]  gain_setting,
	input wire logic        low_power
);
	logic [1:0] age;      // Cycles since reset, saturating
	logic [1:0] ctrl_age; // Cycles since last control write
	logic [4:0] ctrl_q;   // Shadow of the control register
	logic       acc;      // Read access phase
	assign acc = psel && penable && !pwrite;
	// Track reset age and the control shadow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			age <= 2'h0;
			ctrl_age <= 2'h0;
			ctrl_q <= 5'h00;
		end else begin
			if (age != 2'h3) age <= age + 2'h1;
			if (psel && penable && pwrite && paddr == OFS_CTRL) begin
				ctrl_q <= pwdata[4:0];
				ctrl_age <= 2'h0;
			end else if (ctrl_age != 2'h3) ctrl_age <= ctrl_age + 2'h1;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_field; age == 2'h3 |-> field_strength_pin == ($past(agc_in) != GAIN_MAX); endproperty
	a_field: assert property (p_field) else $error("field pin wrong");
	property p_oe_rel; serial_select_n [*6] |-> !fuse_voltage_oe; endproperty
	a_oe_rel: assert property (p_oe_rel) else $error("fuse pin driven outside frame");
	property p_lock; acc && paddr == OFS_STATUS && !adc_lock && !$past(adc_lock) && !$past(adc_lock, 2) |-> !prdata[8];
	endproperty
	a_lock: assert property (p_lock) else $error("lock set while unlocked");
	property p_lp; acc && paddr == OFS_STATUS && low_power && $past(low_power) |-> !prdata[8]; endproperty
	a_lp: assert property (p_lp) else $error("lock set in low power");
	property p_agc; acc && paddr == OFS_STATUS && age == 2'h3 && $stable(agc_in) && agc_in == $past(agc_in, 2)
		&& agc_in == $past(agc_in, 3) |-> prdata[15:10] == agc_in && prdata[9] == (agc_in != GAIN_MAX); endproperty
	a_agc: assert property (p_agc) else $error("gain field wrong");
	property p_trim_lo; acc && paddr == OFS_FUSE_LO |-> prdata[31:16] == FACTORY_TRIM[15:0]; endproperty
	a_trim_lo: assert property (p_trim_lo) else $error("trim low changed");
	property p_trim_hi; acc && paddr == OFS_FUSE_HI |-> prdata[13:0] == FACTORY_TRIM[29:16]; endproperty
	a_trim_hi: assert property (p_trim_hi) else $error("trim high changed");
	property p_gain; ctrl_age == 2'h3 && ctrl_q[4] |-> gain_setting == ctrl_q[3:1]; endproperty
	a_gain: assert property (p_gain) else $error("gain setting wrong");
	property p_lowp; ctrl_age == 2'h3 |-> low_power == ctrl_q[0]; endproperty
	a_lowp: assert property (p_lowp) else $error("low power flag wrong");
	c_lp: cover property (acc && paddr == OFS_STATUS && low_power);
	c_oe: cover property (fuse_voltage_oe);
	c_weak: cover property (!field_strength_pin);
endmodule : tcs_core_assertions
bind tcs_core tcs_core_assertions #(.FACTORY_TRIM(FACTORY_TRIM)) i_tcs_core_assertions (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .serial_select_n(serial_select_n), .fuse_voltage_oe(fuse_voltage_oe), .agc_in(agc_in),
	.adc_lock(adc_lock), .field_strength_pin(field_strength_pin), .gain_setting(gain_setting), .low_power(low_power));

// ### bench/tcs_host_model.sv
// Host controller model driving the serial command pins
`timescale 1ns/10ps
module tcs_host_model (
	output logic      serial_clock_pin,
	output logic      serial_select_n,
	output logic      serial_data_in,
	input  wire logic serial_data_out,
	input  wire logic fuse_voltage_pin
);
	// Idle: clock still low, frame deselected
	initial begin
		serial_clock_pin = 1'b0;
		serial_select_n = 1'b1;
		serial_data_in = 1'b0;
	end
	// One frame: command then n data bits, MSB first; samples taken halfway through each data bit high phase
	task automatic frame(input logic [4:0] cmd, input int n, input logic [45:0] wd,
		output logic [45:0] rsp, output logic [45:0] ana);
		rsp = '0;
		ana = '0;
		#7;
		serial_select_n = 1'b0;
		#160;
		for (int i = 0; i < 5 + n; i++) begin
			serial_clock_pin = 1'b0;
			serial_data_in = (i < 5) ? cmd[4 - i] : wd[n - 1 - (i - 5)];
			#160;
			serial_clock_pin = 1'b1;
			#80;
			if (i >= 5) begin
				rsp = {rsp[44:0], serial_data_out};
				ana = {fuse_voltage_pin, ana[45:1]};
			end
			#80;
		end
		serial_clock_pin = 1'b0;
		#160;
		serial_select_n = 1'b1;
		// Released line shows the inverse of its last level
		serial_data_in = ~serial_data_in;
		#640;
	endtask : frame
	// Host accepts an angle only when locked and gain inside the window
	function automatic logic ok_angle(input logic [16:0] f);
		return f[16] && f[15:10] > 6'h00 && f[15:10] < 6'h2f;
	endfunction : ok_angle
	// Push stroke seen as a departure from the nominal gain
	function automatic logic pushed(input logic [5:0] nominal, input logic [5:0] now);
		return now != nominal;
	endfunction : pushed
endmodule : tcs_host_model

// ### bench/tcs_core_tb_top.sv
// Self-checking bench for the turn counter core
`timescale 1ns/10ps
module tcs_core_tb_top import tcs_pkg::*;;
	localparam logic [29:0] FT = 30'h2bad0c3e; // Arbitrary trim value
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic        sck, sel_n, sdi, sdo, fvo, fvoe, fuse_voltage_pin_v = 0, adc_lock = 1, cw = 0, ccw = 0, fsp, lowp;
	logic [7:0]  paddr = 0, angle_in = 8'h5a;
	logic [31:0] pwdata = 0, prdata, r;
	logic        e;                    // Error response of the last transfer
	logic [5:0]  agc_in = 6'h20;
	logic [2:0]  gain;
	logic [45:0] rsp, ana, word;
	int          failures = 0, n_checks = 0;
	wire         fv = fvoe ? fvo : fuse_voltage_pin_v; // Fuse pin level
	always #20 pclk = ~pclk;
	tcs_core #(.FACTORY_TRIM(FT)) i_tcs_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.serial_clock_pin(sck), .serial_select_n(sel_n), .serial_data_in(sdi), .serial_data_out(sdo),
		.fuse_voltage_in(fv), .fuse_voltage_out(fvo), .fuse_voltage_oe(fvoe), .angle_in(angle_in), .agc_in(agc_in),
		.adc_lock(adc_lock), .cross_cw(cw), .cross_ccw(ccw), .field_strength_pin(fsp), .gain_setting(gain),
		.low_power(lowp));
	tcs_host_model i_tcs_host_model (.serial_clock_pin(sck), .serial_select_n(sel_n), .serial_data_in(sdi),
		.serial_data_out(sdo), .fuse_voltage_pin(fv));
	task automatic print_verdict;
		if (failures == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [45:0] got, input logic [45:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer, then an idle edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		if (k >= 20) begin
			failures++;
			print_verdict;
		end
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk({14'h0, r}, {14'h0, e});
	endtask : rd
	task automatic ser(input logic [4:0] c, input int n, input logic [45:0] d);
		i_tcs_host_model.frame(c, n, d, rsp, ana);
		@(posedge pclk);
	endtask : ser
	task automatic turn(input logic d, input int n);
		repeat (n) begin
			cw <= d;
			ccw <= !d;
			@(posedge pclk);
			cw <= 0;
			ccw <= 0;
			@(posedge pclk);
		end
	endtask : turn
	// Main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rd(OFS_STATUS, 32'h0000_8300);
		rd(OFS_FUSE_HI, {18'h0, FT[29:16]});
		rd(8'h10, 32'h0);
		chk({45'h0, e}, 46'h1);
		rd(OFS_CTRL, 32'h0);
		chk({45'h0, e}, 46'h0);
		for (int c = 0; c < 16; c++) begin
			word = {FT, c[3:0], 12'h0a0};
			ser(CMD_WR_FUSE, 46, word);
			if (c >= 1 && c <= 12) word[c - 1] = 1'b1;
			rd(OFS_FUSE_LO, word[31:0]);
			ser(CMD_RD_FUSE, 46, 46'h0);
			chk(rsp, word);
		end
		ser(CMD_RD_ANA, 46, 46'h0);
		chk(ana, word);
		fuse_voltage_pin_v <= 1;
		ser(CMD_FUSE_VOLTAGE_PIN, 46, '1);
		fuse_voltage_pin_v <= 0;
		rd(OFS_FUSE_LO, {FT[15:0], 16'hffff});
		chk({43'h0, gain}, 46'h7);
		apb(1, OFS_CTRL, 32'h1a);
		turn(1, 3);
		turn(0, 5);
		chk({43'h0, gain}, 46'h5);
		rd(OFS_STATUS, 32'h0000_83fe);
		ser(CMD_RD_MULTI, 17, 46'h0);
		chk(rsp, {29'h0, 1'b1, 6'h20, 1'b0, 8'hfe, ^{6'h21, 8'hfe}});
		ser(CMD_HYSTERESIS_RESET_CMD, 3, 46'h1);
		rd(OFS_STATUS, 32'h0000_8300);
		turn(1, 128);
		rd(OFS_STATUS, 32'h0000_8380);
		ser(CMD_RD_ANGLE, 17, 46'h0);
		chk(rsp, {29'h0, 1'b1, 6'h20, 1'b0, 8'h5b, ^{6'h21, 8'h5b}});
		chk({45'h0, i_tcs_host_model.ok_angle(rsp[16:0])}, 46'h1);
		angle_in <= 8'h5c;
		apb(1, OFS_CTRL, 32'h1);
		ser(CMD_RD_ANGLE, 17, 46'h0);
		chk(rsp, {29'h0, 1'b0, 6'h20, 1'b0, 8'h5d, ^{6'h20, 8'h5d}});
		adc_lock <= 0;
		apb(1, OFS_CTRL, 32'h0);
		rd(OFS_STATUS, 32'h0000_8280);
		agc_in <= 6'h3f;
		repeat (3) @(posedge pclk);
		chk({45'h0, fsp}, 46'h0);
		agc_in <= 6'h3e;
		repeat (3) @(posedge pclk);
		chk({45'h0, fsp}, 46'h1);
		print_verdict;
	end
endmodule : tcs_core_tb_top
